// ==== rx_perf_pkg.sv ====
// Constants, register map and state layout of the receive status block.
// Overview of operation
// R1: Mask bit 0 blocks, 1 passes interrupt.
// R2: Sync search counter steps per 8 ms timeout.
// R3: Counter clears on CRC4 sync or CRC4 off.
// R4: Six-bit wrapping counter; status hides counter bit 1.
// R5: Live search flags for CRC4, CAS, FAS.
// R6: Enabled channel signaling change sets event.
// R7: One-second event set every line second.
// R8: Timer event follows counter update interval.
// R9: Multiframe event every 2 ms, free-running without CAS.
// R10: Source select picks own or first framer second.
// R11: Software keeps first framer source select clear.
// R12: Manual source picks own trigger or global latch.
// R13: Trigger rising edge latches counts, clears counters.
// R14: Host waits 250 us before reading counts.
// R15: Update select chooses one second or short period.
// R16: Accumulation mode picks timed or manual updates.
// R17: Select 0 counts BPVs, skipping HDB3 codewords.
// R18: Select 1 counts same-polarity BPV pairs.
// R19: Software uses BPVs for AMI, CVs for HDB3.
// R20: Line counter ignores sync and saturates.
// R21: Path counter counts E1 CRC4 errors, high first.
// R22: Path counter halts on FAS/CRC4 loss only.
// R23: Latched events stick; masked onto interrupt output.
package rx_perf_pkg;

    // -----------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // -----------------------------------------------------------------
    localparam logic [7:0] IDX_LCV_HIGH = 8'h50;
    localparam logic [7:0] IDX_LCV_LOW = 8'h51;
    localparam logic [7:0] IDX_PCV_HIGH = 8'h52;
    localparam logic [7:0] IDX_PCV_LOW = 8'h53;
    localparam logic [7:0] IDX_SYNC_STATUS = 8'h62;
    localparam logic [7:0] IDX_ERR_CONFIG = 8'h86;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'h93;
    localparam logic [7:0] IDX_ALARM_MASK = 8'hA2;
    localparam logic [7:0] IDX_EVENT_MASK = 8'hA3;
    localparam logic [7:0] IDX_SIG_ENABLE = 8'hC0;

    // -----------------------------------------------------------------
    // Field positions and write masks.
    // -----------------------------------------------------------------
    localparam int ERC_SEC_SRC = 7;
    localparam int ERC_MAN_SRC = 6;
    localparam int ERC_MAN_TRIG = 5;
    localparam int ERC_SHORT = 4;
    localparam int ERC_MANUAL = 3;
    localparam int ERC_CV_SEL = 0;
    localparam logic [7:0] ERC_WMASK = 8'hF9;
    localparam logic [7:0] ALARM_MASK_WMASK = 8'hBB;
    localparam int EV_SIG = 3;
    localparam int EV_SEC = 2;
    localparam int EV_TIMER = 1;
    localparam int EV_MF = 0;

    // -----------------------------------------------------------------
    // Timing, given in nanoseconds and counted in received frames.
    // -----------------------------------------------------------------
    localparam int FRAME_NS = 125000;
    localparam int SECOND_NS = 1000000000;
    localparam int MF_NS = 2000000;
    localparam int FRAMES_PER_SEC = SECOND_NS / FRAME_NS;
    localparam int FRAMES_PER_MF = MF_NS / FRAME_NS;
    localparam int T1_SHORT_FRAMES = 336;
    localparam int E1_SHORT_FRAMES = 500;
    localparam logic [12:0] SEC_LAST = 13'(FRAMES_PER_SEC - 1);
    localparam logic [8:0] T1_SHORT_LAST = 9'(T1_SHORT_FRAMES - 1);
    localparam logic [8:0] E1_SHORT_LAST = 9'(E1_SHORT_FRAMES - 1);
    localparam logic [3:0] MF_LAST = 4'(FRAMES_PER_MF - 1);

    // -----------------------------------------------------------------
    // Widths and the whole state of the block.
    // -----------------------------------------------------------------
    localparam int NUM_CHAN = 32;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [5:0] csc;
        logic [3:0] events;
        logic [3:0] ev_mask;
        logic [7:0] alarm_mask;
        logic [7:0] error_counter_config;
        logic [NUM_CHAN-1:0] sig_en;
        logic [15:0] lcv_cnt;
        logic [15:0] pcv_cnt;
        logic [15:0] lcv_reg;
        logic [15:0] pcv_reg;
        logic last_pol;
        logic man_prev;
        logic [12:0] sec_cnt;
        logic [8:0] short_cnt;
        logic [3:0] mf_cnt;
        logic sec_out;
        logic irq;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        logic ready;
    } state_t;

endpackage : rx_perf_pkg

// ==== rx_perf_status.sv ====
// Receive status, periodic events and error counters behind AHB-Lite.
`timescale 1ns/1ps
module rx_perf_status (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic RX_FRAME_PULSE,
    input wire logic T1_MODE,
    input wire logic CRC4_ENABLE,
    input wire logic CAS_ENABLE,
    input wire logic HDB3_ENABLE,
    input wire logic CRC4_SEARCH_ACTIVE,
    input wire logic CAS_SEARCH_ACTIVE,
    input wire logic FAS_SEARCH_ACTIVE,
    input wire logic CRC4_SEARCH_TIMEOUT,
    input wire logic CRC4_SYNC_ACHIEVED,
    input wire logic CAS_MF_BOUNDARY,
    input wire logic [rx_perf_pkg::NUM_CHAN-1:0] SIG_CHANGE,
    input wire logic BPV_PULSE,
    input wire logic BPV_POSITIVE,
    input wire logic HDB3_CODEWORD,
    input wire logic CRC4_ERROR,
    input wire logic GLOBAL_COUNTER_LATCH,
    input wire logic ONE_SEC_REF_IN,
    input wire logic [7:0] ALARM_EVENTS,
    output logic ONE_SEC_REF_OUT,
    output logic IRQ
);
    import rx_perf_pkg::*;

    localparam state_t RESET_STATE = '{ready: 1'b1, default: '0};

    state_t s_q;
    state_t s_d;
    logic sec_tick;
    logic short_tick;
    logic mf_tick;
    logic timed_tick;
    logic man_level;
    logic latch_now;
    logic lcv_inc;
    logic pcv_inc;
    logic sig_event;
    logic addr_take;
    logic clr_write;
    logic [7:0] idx;

    // -----------------------------------------------------------------
    // Frame timers and the event sources they feed.
    // -----------------------------------------------------------------

    // Frame counts wrap on the last frame of each interval.
    always_comb begin
        sec_tick = RX_FRAME_PULSE && (s_q.sec_cnt == SEC_LAST); // [R7]
        short_tick = RX_FRAME_PULSE && (s_q.short_cnt ==
            (T1_MODE ? T1_SHORT_LAST : E1_SHORT_LAST)); // [R15]
        if (CAS_ENABLE) begin
            mf_tick = CAS_MF_BOUNDARY; // [R9]
        end else begin
            mf_tick = RX_FRAME_PULSE && (s_q.mf_cnt == MF_LAST); // [R9]
        end
        if (s_q.error_counter_config[ERC_SHORT]) begin
            timed_tick = short_tick; // [R15]
        end else if (s_q.error_counter_config[ERC_SEC_SRC]) begin
            timed_tick = ONE_SEC_REF_IN; // [R10]
        end else begin
            timed_tick = sec_tick; // [R10]
        end
    end

    // Counter latch trigger, count enables and signaling change.
    always_comb begin
        man_level = s_q.error_counter_config[ERC_MAN_SRC] ? GLOBAL_COUNTER_LATCH
                                           : s_q.error_counter_config[ERC_MAN_TRIG]; // [R12]
        if (s_q.error_counter_config[ERC_MANUAL]) begin
            latch_now = man_level && !s_q.man_prev; // [R13] [R16]
        end else begin
            latch_now = timed_tick; // [R16]
        end
        if (s_q.error_counter_config[ERC_CV_SEL]) begin
            lcv_inc = BPV_PULSE && (BPV_POSITIVE == s_q.last_pol); // [R18]
        end else begin
            lcv_inc = BPV_PULSE && !(HDB3_ENABLE && HDB3_CODEWORD); // [R17]
        end
        pcv_inc = CRC4_ERROR && !T1_MODE &&
                  !FAS_SEARCH_ACTIVE && !CRC4_SEARCH_ACTIVE; // [R21] [R22]
        sig_event = |(SIG_CHANGE & s_q.sig_en); // [R6]
    end

    // -----------------------------------------------------------------
    // Bus decode.
    // -----------------------------------------------------------------

    // A transfer is taken when the address phase meets HREADY high.
    always_comb begin
        addr_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
        idx = HADDR[9:2];
        clr_write = s_q.wr_pend && (s_q.wr_idx == IDX_EVENT_STATUS);
    end

    // -----------------------------------------------------------------
    // Next state.
    // -----------------------------------------------------------------

    // One pass computes timers, counters, registers and bus answers.
    always_comb begin
        s_d = s_q;

        // Timers count received frames.
        if (RX_FRAME_PULSE) begin
            s_d.sec_cnt = sec_tick ? '0 : s_q.sec_cnt + 13'h1;
            s_d.short_cnt = short_tick ? '0 : s_q.short_cnt + 9'h1;
            s_d.mf_cnt = (s_q.mf_cnt == MF_LAST) ? '0
                                                 : s_q.mf_cnt + 4'h1;
        end
        if (CAS_ENABLE && CAS_MF_BOUNDARY) begin
            s_d.mf_cnt = '0;
        end
        s_d.sec_out = sec_tick;

        // Search counter wraps at six bits.
        if (!CRC4_ENABLE || CRC4_SYNC_ACHIEVED) begin
            s_d.csc = '0; // [R3]
        end else if (CRC4_SEARCH_TIMEOUT) begin
            s_d.csc = s_q.csc + 6'h1; // [R2] [R4]
        end

        // Error counters and their holding registers.
        if (BPV_PULSE) begin
            s_d.last_pol = BPV_POSITIVE;
        end
        s_d.man_prev = man_level;
        if (latch_now) begin
            s_d.lcv_reg = s_q.lcv_cnt; // [R13]
            s_d.pcv_reg = s_q.pcv_cnt; // [R13]
            s_d.lcv_cnt = {15'h0, lcv_inc};
            s_d.pcv_cnt = {15'h0, pcv_inc};
        end else begin
            if (lcv_inc && s_q.lcv_cnt != CNT_MAX) begin
                s_d.lcv_cnt = s_q.lcv_cnt + 16'h1; // [R20]
            end
            if (pcv_inc) begin
                s_d.pcv_cnt = s_q.pcv_cnt + 16'h1; // [R21]
            end
        end

        // Register writes land in the data phase.
        if (s_q.wr_pend) begin
            unique case (s_q.wr_idx)
                IDX_ERR_CONFIG: s_d.error_counter_config = HWDATA[7:0] & ERC_WMASK;
                IDX_EVENT_STATUS: s_d.events = s_q.events & ~HWDATA[3:0];
                IDX_ALARM_MASK: begin
                    s_d.alarm_mask = HWDATA[7:0] & ALARM_MASK_WMASK;
                end
                IDX_EVENT_MASK: s_d.ev_mask = HWDATA[3:0];
                IDX_SIG_ENABLE: s_d.sig_en = HWDATA[NUM_CHAN-1:0];
                default: s_d.events = s_q.events;
            endcase
        end

        // New events are set after the clear, so a set wins.
        if (sig_event) begin
            s_d.events[EV_SIG] = 1'b1; // [R6] [R23]
        end
        if (sec_tick) begin
            s_d.events[EV_SEC] = 1'b1; // [R7] [R23]
        end
        if (timed_tick) begin
            s_d.events[EV_TIMER] = 1'b1; // [R8] [R23]
        end
        if (mf_tick) begin
            s_d.events[EV_MF] = 1'b1; // [R9] [R23]
        end

        // Mask bits gate both event groups onto the interrupt.
        s_d.irq = |(s_d.events & s_d.ev_mask) |
                  |(ALARM_EVENTS & s_d.alarm_mask); // [R1] [R23]

        // Address phase: capture writes, prepare read data.
        s_d.wr_pend = addr_take && HWRITE;
        s_d.wr_idx = idx;
        s_d.ready = 1'b1;
        if (addr_take && !HWRITE && HADDR[31:10] == '0) begin
            unique case (idx)
                IDX_LCV_HIGH: s_d.rdata = {24'h0, s_q.lcv_reg[15:8]};
                IDX_LCV_LOW: s_d.rdata = {24'h0, s_q.lcv_reg[7:0]};
                IDX_PCV_HIGH: s_d.rdata = {24'h0, s_q.pcv_reg[15:8]};
                IDX_PCV_LOW: s_d.rdata = {24'h0, s_q.pcv_reg[7:0]};
                IDX_SYNC_STATUS: begin
                    s_d.rdata = {24'h0, s_q.csc[5:2], s_q.csc[0],
                                 CRC4_SEARCH_ACTIVE, CAS_SEARCH_ACTIVE,
                                 FAS_SEARCH_ACTIVE}; // [R4] [R5]
                end
                IDX_ERR_CONFIG: s_d.rdata = {24'h0, s_q.error_counter_config};
                IDX_EVENT_STATUS: s_d.rdata = {28'h0, s_q.events};
                IDX_ALARM_MASK: s_d.rdata = {24'h0, s_q.alarm_mask};
                IDX_EVENT_MASK: s_d.rdata = {28'h0, s_q.ev_mask};
                IDX_SIG_ENABLE: s_d.rdata = s_q.sig_en;
                default: s_d.rdata = 32'h0;
            endcase
        end else if (addr_take) begin
            s_d.rdata = 32'h0;
        end
        if (s_d.wr_pend && HADDR[31:10] != '0) begin
            s_d.wr_idx = 8'h00;
        end
    end

    // -----------------------------------------------------------------
    // State register and outputs.
    // -----------------------------------------------------------------

    // Synchronous reset loads the constant reset state.
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            s_q <= RESET_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // Every output but HRESP, which is tied low, is a field of the state register.
    always_comb begin
        HRDATA = s_q.rdata;
        HREADYOUT = s_q.ready;
        HRESP = 1'b0;
        ONE_SEC_REF_OUT = s_q.sec_out;
        IRQ = s_q.irq;
    end

    // -----------------------------------------------------------------
    // Checks.
    // -----------------------------------------------------------------

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SYS_RST);

    sequence s_manual_edge;
        s_q.error_counter_config[ERC_MANUAL] && !s_q.error_counter_config[ERC_MAN_SRC] &&
            s_q.error_counter_config[ERC_MAN_TRIG] && !s_q.man_prev;
    endsequence

    sequence s_counts_loaded;
        s_q.lcv_reg == $past(s_q.lcv_cnt) &&
            s_q.pcv_reg == $past(s_q.pcv_cnt) && s_q.lcv_cnt <= 16'h1;
    endsequence

    a_search_count_clear: assert property ( // [R3]
        !CRC4_ENABLE |=> s_q.csc == 6'h0)
        else $error("search counter not cleared with CRC4 off");

    a_search_count_step: assert property ( // [R2]
        CRC4_ENABLE && CRC4_SEARCH_TIMEOUT && !CRC4_SYNC_ACHIEVED
            |=> s_q.csc == $past(s_q.csc) + 6'h1)
        else $error("search counter did not advance on timeout");

    a_manual_latch: assert property ( // [R13]
        s_manual_edge |=> s_counts_loaded)
        else $error("manual trigger edge did not latch counts");

    a_line_saturate: assert property ( // [R20]
        s_q.lcv_cnt == CNT_MAX && !latch_now |=> s_q.lcv_cnt == CNT_MAX)
        else $error("line violation counter wrapped");

    a_path_hold_lof: assert property ( // [R22]
        (FAS_SEARCH_ACTIVE || CRC4_SEARCH_ACTIVE) && !latch_now
            |=> $stable(s_q.pcv_cnt))
        else $error("path counter moved during loss of sync");

    a_event_sticky: assert property ( // [R23]
        !clr_write |=> (s_q.events & $past(s_q.events)) == $past(s_q.events))
        else $error("latched event dropped without a clear");

    a_second_event: assert property ( // [R7]
        sec_tick |=> s_q.events[EV_SEC] && ONE_SEC_REF_OUT)
        else $error("one-second event not raised");

    a_mf_event: assert property ( // [R9]
        !CAS_ENABLE && RX_FRAME_PULSE && s_q.mf_cnt == MF_LAST
            |=> s_q.events[EV_MF])
        else $error("free-running multiframe event missed");

    a_irq_masked: assert property ( // [R1]
        s_q.ev_mask == 4'h0 && s_q.alarm_mask == 8'h0 |-> !IRQ)
        else $error("interrupt raised with all masks clear");

endmodule : rx_perf_status

// ==== rx_perf_status_tb_top.sv ====
// Self-checking bench for the receive status and error counter block.
`timescale 1ns/1ps
module rx_perf_status_tb_top;
    import rx_perf_pkg::*;
    // ---------------------------------------------------------------
    // Signals of the block and of the bench.
    // ---------------------------------------------------------------
    localparam logic [5:0] frm = 6'h20, tmo = 6'h10, syn = 6'h08;
    localparam logic [5:0] cmf = 6'h04, crce = 6'h02, sref = 6'h01;
    logic CLK_SYS = 0, SYS_RST = 1, HSEL = 0, HWRITE = 0, rd_ph = 0;
    logic [31:0] HADDR = 0, HWDATA = 0, HRDATA;
    logic [1:0] HTRANS = 0;
    logic [2:0] HSIZE = 3'h2, sa = 0;
    logic HREADYOUT, HRESP, ONE_SEC_REF_OUT, IRQ, sec_seen = 0, prev;
    logic T1_MODE = 0, CRC4_ENABLE = 1, CAS_ENABLE = 0, HDB3_ENABLE = 0;
    logic BPV_PULSE = 0, BPV_POSITIVE = 0, HDB3_CODEWORD = 0;
    logic GLOBAL_COUNTER_LATCH = 0;
    logic RX_FRAME_PULSE, CRC4_SEARCH_TIMEOUT, CRC4_SYNC_ACHIEVED;
    logic CAS_MF_BOUNDARY, CRC4_ERROR, ONE_SEC_REF_IN;
    logic CRC4_SEARCH_ACTIVE, CAS_SEARCH_ACTIVE, FAS_SEARCH_ACTIVE;
    logic [NUM_CHAN-1:0] SIG_CHANGE = 0, one;
    logic [7:0] ALARM_EVENTS = 0, ch, bm;
    logic [5:0] pv = 0, csc;
    logic [31:0] exp_q[$];
    int n_fail = 0, checks = 0, cnt, pcv;
    int abit[6] = '{7, 5, 4, 3, 1, 0};
    logic [7:0] regs[9] = '{IDX_LCV_HIGH, IDX_LCV_LOW, IDX_PCV_HIGH,
        IDX_PCV_LOW, IDX_SYNC_STATUS, IDX_ERR_CONFIG, IDX_EVENT_STATUS,
        IDX_EVENT_MASK, 8'h07};

    // Pulse inputs and search levels come from two bench variables.
    assign {RX_FRAME_PULSE, CRC4_SEARCH_TIMEOUT, CRC4_SYNC_ACHIEVED,
        CAS_MF_BOUNDARY, CRC4_ERROR, ONE_SEC_REF_IN} = pv;
    assign {CRC4_SEARCH_ACTIVE, CAS_SEARCH_ACTIVE, FAS_SEARCH_ACTIVE} = sa;

    rx_perf_status u_dut (
        .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .RX_FRAME_PULSE(RX_FRAME_PULSE), .T1_MODE(T1_MODE),
        .CRC4_ENABLE(CRC4_ENABLE), .CAS_ENABLE(CAS_ENABLE),
        .HDB3_ENABLE(HDB3_ENABLE), .CRC4_SEARCH_ACTIVE(CRC4_SEARCH_ACTIVE),
        .CAS_SEARCH_ACTIVE(CAS_SEARCH_ACTIVE),
        .FAS_SEARCH_ACTIVE(FAS_SEARCH_ACTIVE),
        .CRC4_SEARCH_TIMEOUT(CRC4_SEARCH_TIMEOUT),
        .CRC4_SYNC_ACHIEVED(CRC4_SYNC_ACHIEVED),
        .CAS_MF_BOUNDARY(CAS_MF_BOUNDARY), .SIG_CHANGE(SIG_CHANGE),
        .BPV_PULSE(BPV_PULSE), .BPV_POSITIVE(BPV_POSITIVE),
        .HDB3_CODEWORD(HDB3_CODEWORD), .CRC4_ERROR(CRC4_ERROR),
        .GLOBAL_COUNTER_LATCH(GLOBAL_COUNTER_LATCH),
        .ONE_SEC_REF_IN(ONE_SEC_REF_IN), .ALARM_EVENTS(ALARM_EVENTS),
        .ONE_SEC_REF_OUT(ONE_SEC_REF_OUT), .IRQ(IRQ)
    );

    // Free-running 200 MHz clock.
    initial begin
        forever #2.5 CLK_SYS = ~CLK_SYS;
    end

    // ---------------------------------------------------------------
    // Compare, verdict and bus tasks.
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask : cyc

    // One AHB single transfer; the request holds until hready is seen.
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] d);
        HSEL <= 1;
        HTRANS <= HTRANS_NONSEQ;
        HWRITE <= w;
        HADDR <= {22'h0, idx, 2'h0};
        do cyc(1); while (HREADYOUT !== 1'b1);
        HSEL <= 0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        rd_ph <= !w;
        do cyc(1); while (HREADYOUT !== 1'b1);
        rd_ph <= 0;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1, idx, d);
    endtask : wr

    // A read notes its expected word; the monitor compares it later.
    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        exp_q.push_back(e);
        bus(0, idx, 0);
    endtask : rd

    task automatic cnt_is(input logic [7:0] hi, input logic [15:0] v);
        rd(hi, {24'h0, v[15:8]});
        rd(hi + 8'h01, {24'h0, v[7:0]});
    endtask : cnt_is

    task automatic pulse(input logic [5:0] m, input int n);
        repeat (n) begin
            pv <= m;
            cyc(1);
            pv <= 0;
            cyc(1);
        end
    endtask : pulse

    task automatic bpv(input logic pos, input logic cw);
        BPV_PULSE <= 1;
        BPV_POSITIVE <= pos;
        HDB3_CODEWORD <= cw;
        cyc(1);
        BPV_PULSE <= 0;
        HDB3_CODEWORD <= 0;
        cyc(1);
    endtask : bpv

    task automatic irq_is(input logic v);
        cyc(1);
        #1 check("irq", IRQ, v);
        cyc(1);
    endtask : irq_is

    // Read data is taken at the edge that ends its data phase.
    always @(posedge CLK_SYS) begin
        if (rd_ph && HREADYOUT === 1'b1) begin
            check("read data", HRDATA, exp_q.pop_front());
            check("response", HRESP, 0);
        end
        if (ONE_SEC_REF_OUT === 1'b1) begin
            sec_seen <= 1;
        end
    end

    // Watchdog well beyond the expected run of some 85000 cycles.
    initial begin
        #600000;
        n_fail++;
        give_verdict();
    end

    // ---------------------------------------------------------------
    // Main sequence.
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'hB23A));
        cyc(2);
        SYS_RST <= 0;
        cyc(2);
        foreach (regs[i]) rd(regs[i], 0);
        wr(IDX_ERR_CONFIG, 32'hFF);
        rd(IDX_ERR_CONFIG, 32'hF9);
        wr(IDX_EVENT_MASK, 32'hFF);
        rd(IDX_EVENT_MASK, 32'h0F);
        wr(IDX_ALARM_MASK, 32'hFF);
        rd(IDX_ALARM_MASK, 32'hBB);
        // Search timeouts wrap the counter; every search flag combination.
        for (int i = 0; i < 8; i++) begin
            pulse(tmo, 9);
            csc = 6'(9 * (i + 1));
            sa <= 3'(i);
            rd(IDX_SYNC_STATUS, {csc[5:2], csc[0], 3'(i)});
        end
        pulse(syn, 1);
        rd(IDX_SYNC_STATUS, 32'h07);
        pulse(tmo, 3);
        CRC4_ENABLE <= 0;
        cyc(1);
        rd(IDX_SYNC_STATUS, 32'h07);
        CRC4_ENABLE <= 1;
        sa <= 0;
        // Each writable alarm mask bit (all but bits 2 and 6) blocks at 0 and passes at 1.
        foreach (abit[i]) begin
            bm = 8'h01 << abit[i];
            ALARM_EVENTS <= bm;
            wr(IDX_ALARM_MASK, {24'h0, ~bm});
            irq_is(0);
            wr(IDX_ALARM_MASK, {24'h0, bm});
            irq_is(1);
        end
        ALARM_EVENTS <= 0;
        wr(IDX_ALARM_MASK, 0);
        // Signaling change on enabled and disabled channels.
        one = NUM_CHAN'(1) << $urandom_range(NUM_CHAN - 1, 0);
        wr(IDX_SIG_ENABLE, one);
        wr(IDX_EVENT_MASK, 32'h08);
        SIG_CHANGE <= ~one;
        cyc(1);
        SIG_CHANGE <= 0;
        irq_is(0);
        SIG_CHANGE <= one;
        cyc(1);
        SIG_CHANGE <= 0;
        irq_is(1);
        rd(IDX_EVENT_STATUS, 32'h08);
        wr(IDX_EVENT_MASK, 32'h00);
        irq_is(0);
        rd(IDX_EVENT_STATUS, 32'h08);
        wr(IDX_EVENT_MASK, 32'h08);
        irq_is(1);
        wr(IDX_EVENT_STATUS, 32'h08);
        irq_is(0);
        CAS_ENABLE <= 1;
        pulse(cmf, 1);
        rd(IDX_EVENT_STATUS, 32'h01);
        CAS_ENABLE <= 0;
        wr(IDX_EVENT_STATUS, 32'h0F);
        // Bipolar violations in manual mode, codewords not counted.
        wr(IDX_ERR_CONFIG, 32'h08);
        HDB3_ENABLE <= 1;
        cnt = 0;
        for (int i = 0; i < 20; i++) begin
            ch = 8'($urandom);
            bpv(ch[0], ch[1] && i < 19);
            cnt += !(ch[1] && i < 19);
            prev = ch[0];
        end
        wr(IDX_ERR_CONFIG, 32'h28);
        cyc(2);
        cnt_is(IDX_LCV_HIGH, 16'(cnt));
        // Code violations, then path errors under changing sync loss.
        wr(IDX_ERR_CONFIG, 32'h09);
        cnt = 0;
        pcv = 0;
        for (int i = 0; i < 20; i++) begin
            ch = 8'($urandom);
            bpv(ch[0], 0);
            cnt += (ch[0] == prev);
            prev = ch[0];
            sa <= ch[3:1];
            pulse(crce, 1);
            pcv += !(ch[3] || ch[1]);
        end
        sa <= 0;
        wr(IDX_ERR_CONFIG, 32'h29);
        cyc(2);
        cnt_is(IDX_LCV_HIGH, 16'(cnt));
        cnt_is(IDX_PCV_HIGH, 16'(pcv));
        // Global latch as the manual source; own trigger then ignored.
        wr(IDX_ERR_CONFIG, 32'h48);
        repeat (3) bpv(1'b0, 1'b0);
        wr(IDX_ERR_CONFIG, 32'h68);
        cyc(2);
        rd(IDX_LCV_LOW, {24'h0, 8'(cnt)});
        GLOBAL_COUNTER_LATCH <= 1;
        cyc(3);
        GLOBAL_COUNTER_LATCH <= 0;
        // Line counter stops at its top value; the global latch result
        // is read only after the host's settling wait has passed.
        wr(IDX_ERR_CONFIG, 32'h08);
        BPV_PULSE <= 1;
        cyc(65540);
        BPV_PULSE <= 0;
        cnt_is(IDX_LCV_HIGH, 16'h0003);
        wr(IDX_ERR_CONFIG, 32'h28);
        cyc(2);
        cnt_is(IDX_LCV_HIGH, 16'hFFFF);
        // Timed latch on the shared one-second reference.
        wr(IDX_ERR_CONFIG, 32'h80);
        repeat (4) bpv(1'b1, 1'b0);
        pulse(sref, 1);
        cyc(2);
        cnt_is(IDX_LCV_HIGH, 16'h0004);
        // Frame-timed events: multiframe, short period, one second.
        wr(IDX_EVENT_MASK, 32'h0F);
        wr(IDX_ERR_CONFIG, 32'h10);
        wr(IDX_EVENT_STATUS, 32'h0F);
        pulse(frm, 15);
        rd(IDX_EVENT_STATUS, 32'h00);
        pulse(frm, 1);
        rd(IDX_EVENT_STATUS, 32'h01);
        pulse(frm, 483);
        rd(IDX_EVENT_STATUS, 32'h01);
        pulse(frm, 1);
        rd(IDX_EVENT_STATUS, 32'h03);
        wr(IDX_ERR_CONFIG, 32'h00);
        wr(IDX_EVENT_STATUS, 32'h0F);
        pulse(frm, 7499);
        rd(IDX_EVENT_STATUS, 32'h01);
        check("second out", sec_seen, 0);
        wr(IDX_EVENT_STATUS, 32'h0F);
        pulse(frm, 1);
        rd(IDX_EVENT_STATUS, 32'h07);
        check("second out", sec_seen, 1);
        irq_is(1);
        // T1 short period of 336 frames; path errors are not counted.
        T1_MODE <= 1;
        wr(IDX_ERR_CONFIG, 32'h10);
        wr(IDX_EVENT_STATUS, 32'h0F);
        pulse(crce, 1);
        pulse(frm, 335);
        rd(IDX_EVENT_STATUS, 32'h01);
        pulse(frm, 1);
        rd(IDX_EVENT_STATUS, 32'h03);
        cnt_is(IDX_PCV_HIGH, 16'h0000);
        give_verdict();
    end
endmodule : rx_perf_status_tb_top
